// >>> logic/sdpsp_pkg.sv
// Purpose: Shared constants and carrier types for the servo drive parameter, status and probe block.
// Assumes: One clock at 125 MHz; the service channel delivers one parameter access at a time.
// Notes: Parameter numbers are the ring parameter numbers; the service channel addresses by them.
package sdpsp_pkg;

  // ----------------------------------------------------------------
  // Parameter numbers
  // ----------------------------------------------------------------
  localparam logic [15:0] PN_TORQUE_THR   = 16'h007E;
  localparam logic [15:0] PN_P3_CHECK     = 16'h007F;
  localparam logic [15:0] PN_P4_CHECK     = 16'h0080;
  localparam logic [15:0] PN_VENDOR_FAULT = 16'h0081;
  localparam logic [15:0] PN_P1_RISE      = 16'h0082;
  localparam logic [15:0] PN_P1_FALL      = 16'h0083;
  localparam logic [15:0] PN_P2_RISE      = 16'h0084;
  localparam logic [15:0] PN_P2_FALL      = 16'h0085;
  localparam logic [15:0] PN_MASTER_CTRL  = 16'h0086;
  localparam logic [15:0] PN_DRIVE_STAT   = 16'h0087;
  localparam logic [15:0] PN_ACCEL_LIMIT  = 16'h008A;
  localparam logic [15:0] PN_C1_RESET     = 16'h0063;

  // ----------------------------------------------------------------
  // Ranges and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] TORQUE_THR_MAX   = 16'h2710;
  localparam logic [15:0] TORQUE_THR_RST   = 16'h0000;
  localparam logic [31:0] ACCEL_LIMIT_MAX  = 32'h017D7840;
  localparam logic [31:0] ACCEL_LIMIT_RST  = 32'h017D7840;
  localparam logic [15:0] PROC_RST         = 16'h0000;
  localparam logic [15:0] PROC_EXECUTE     = 16'h0003;
  localparam logic [31:0] CAPTURE_RST      = 32'h00000000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int C3_STANDSTILL_BIT = 0;
  localparam int C3_BELOW_NX_BIT   = 1;
  localparam int C3_TORQUE_BIT     = 2;
  localparam int FAULT_USED_BITS   = 7;
  localparam int FAULT_SYNC_BIT    = 0;
  localparam int FAULT_MEMLOSS_BIT = 1;
  localparam int FAULT_IONET_BIT   = 2;
  localparam int FAULT_REGEN_BIT   = 3;
  localparam int FAULT_PWRBRD_BIT  = 4;
  localparam int FAULT_PWRMOD_BIT  = 5;
  localparam int FAULT_CYCLE_BIT   = 6;

  // ----------------------------------------------------------------
  // Modes and carriers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PHASE0 = 3'h0, PHASE1 = 3'h1, PHASE2 = 3'h2, PHASE3 = 3'h3, PHASE4 = 3'h4
  } sdpsp_phase_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] param;
    logic [31:0] wdata;
  } sdpsp_req_t;

  typedef struct packed {
    logic        valid;
    logic        err;
    logic [31:0] rdata;
  } sdpsp_rsp_t;

  typedef struct packed {
    logic active;
    logic done;
    logic error;
  } sdpsp_proc_t;

endpackage : sdpsp_pkg

// >>> logic/sdpsp_edge_capture.sv
// Purpose: Latches a position value on each rising and each falling edge of one probe input.
// Assumes: The probe input is synchronous to the clock.
// Notes: The captures hold until the next edge of the same kind.
`timescale 1ns/100ps
module sdpsp_edge_capture #(
  parameter int WIDTH = 32
) (
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire logic             probe,
  input  wire logic [WIDTH-1:0] position,
  output logic      [WIDTH-1:0] rise_capture,
  output logic      [WIDTH-1:0] fall_capture
);

  if (WIDTH < 1 || WIDTH > 32) begin : g_width_check
    $error("sdpsp_edge_capture: WIDTH must be 1 to 32");
  end

  logic probe_reg;
  wire  rise_hit = probe & ~probe_reg;
  wire  fall_hit = ~probe & probe_reg;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      probe_reg    <= 1'b0;
      rise_capture <= WIDTH'(sdpsp_pkg::CAPTURE_RST);
      fall_capture <= WIDTH'(sdpsp_pkg::CAPTURE_RST);
    end else begin
      probe_reg <= probe;
      if (rise_hit) begin
        rise_capture <= position;
      end
      if (fall_hit) begin
        fall_capture <= position;
      end
    end
  end

endmodule : sdpsp_edge_capture

// >>> logic/sdpsp_param_block.sv
// Purpose: Parameter bank, status flags, fault latch, readiness checks, probe capture and acceleration clamp.
// Assumes: One service channel access at a time; the communication phase comes from the ring logic.
// Notes: Answers come one clock after the request; every refused write leaves storage unchanged.
`timescale 1ns/100ps
module sdpsp_param_block (
  input  wire logic                  core_clk,
  input  wire logic                  arst_n,
  input  wire sdpsp_pkg::sdpsp_req_t svc_req,
  output sdpsp_pkg::sdpsp_rsp_t      svc_rsp,
  input  wire logic [2:0]            comm_phase,
  input  wire logic                  p3_params_loaded,
  input  wire logic                  p4_params_loaded,
  output sdpsp_pkg::sdpsp_proc_t     p3_check_status,
  output sdpsp_pkg::sdpsp_proc_t     p4_check_status,
  input  wire logic [15:0]           torque_feedback,
  input  wire logic                  vel_standstill,
  input  wire logic                  vel_below_nx,
  output logic      [15:0]           class3_status_word,
  input  wire logic [6:0]            fault_condition,
  output logic                       class1_vendor_error,
  input  wire logic                  probe1_in,
  input  wire logic                  probe2_in,
  input  wire logic                  probe_source_sel,
  input  wire logic [31:0]           motor_position,
  input  wire logic [31:0]           external_position,
  input  wire logic [15:0]           master_control_word,
  input  wire logic [15:0]           drive_status_word,
  input  wire logic [31:0]           accel_command,
  output logic      [31:0]           accel_clamped
);

  // ----------------------------------------------------------------
  // Stored parameters
  // ----------------------------------------------------------------
  logic [15:0] torque_threshold_level_reg;
  logic [15:0] phase3_readiness_check_cmd_reg;
  logic [15:0] phase4_readiness_check_cmd_reg;
  logic [15:0] vendor_fault_flags_reg;
  logic [15:0] vendor_fault_flags_next;
  logic [31:0] accel_limit_symmetric_reg;
  logic [31:0] probe1_rise_capture;
  logic [31:0] probe1_fall_capture;
  logic [31:0] probe2_rise_capture;
  logic [31:0] probe2_fall_capture;

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  wire logic in_p2  = (comm_phase == 3'(sdpsp_pkg::PHASE2));
  wire logic in_p3  = (comm_phase == 3'(sdpsp_pkg::PHASE3));
  wire logic in_p4  = (comm_phase == 3'(sdpsp_pkg::PHASE4));
  wire logic in_p234 = in_p2 | in_p3 | in_p4;
  wire logic do_wr  = svc_req.valid & svc_req.write;
  wire logic do_rd  = svc_req.valid & ~svc_req.write;

  wire logic hit_thr   = (svc_req.param == sdpsp_pkg::PN_TORQUE_THR);
  wire logic hit_p3    = (svc_req.param == sdpsp_pkg::PN_P3_CHECK);
  wire logic hit_p4    = (svc_req.param == sdpsp_pkg::PN_P4_CHECK);
  wire logic hit_fault = (svc_req.param == sdpsp_pkg::PN_VENDOR_FAULT);
  wire logic hit_p1r   = (svc_req.param == sdpsp_pkg::PN_P1_RISE);
  wire logic hit_p1f   = (svc_req.param == sdpsp_pkg::PN_P1_FALL);
  wire logic hit_p2r   = (svc_req.param == sdpsp_pkg::PN_P2_RISE);
  wire logic hit_p2f   = (svc_req.param == sdpsp_pkg::PN_P2_FALL);
  wire logic hit_mcw   = (svc_req.param == sdpsp_pkg::PN_MASTER_CTRL);
  wire logic hit_dsw   = (svc_req.param == sdpsp_pkg::PN_DRIVE_STAT);
  wire logic hit_acc   = (svc_req.param == sdpsp_pkg::PN_ACCEL_LIMIT);
  wire logic hit_c1rst = (svc_req.param == sdpsp_pkg::PN_C1_RESET);

  wire logic hit_ro = hit_fault | hit_p1r | hit_p1f | hit_p2r | hit_p2f | hit_mcw | hit_dsw;
  wire logic hit_rw = hit_thr | hit_p3 | hit_p4 | hit_acc;
  wire logic hit_any = hit_ro | hit_rw | hit_c1rst;

  // Write windows per parameter: thresholds and limits in phases 2-4, checks only in the phase they leave.
  wire logic thr_ok   = in_p234 & (svc_req.wdata[31:16] == 16'h0000)
                      & (svc_req.wdata[15:0] <= sdpsp_pkg::TORQUE_THR_MAX);
  wire logic acc_ok   = in_p234 & (svc_req.wdata <= sdpsp_pkg::ACCEL_LIMIT_MAX);
  wire logic p3_ok    = in_p2 & (svc_req.wdata[31:16] == 16'h0000);
  wire logic p4_ok    = in_p3 & (svc_req.wdata[31:16] == 16'h0000);

  wire logic wr_thr   = do_wr & hit_thr & thr_ok;
  wire logic wr_acc   = do_wr & hit_acc & acc_ok;
  wire logic wr_p3    = do_wr & hit_p3 & p3_ok;
  wire logic wr_p4    = do_wr & hit_p4 & p4_ok;
  wire logic c1_reset = do_wr & hit_c1rst;

  wire logic wr_refused = do_wr & ((hit_ro)
                                 | (hit_thr & ~thr_ok)
                                 | (hit_acc & ~acc_ok)
                                 | (hit_p3 & ~p3_ok)
                                 | (hit_p4 & ~p4_ok)
                                 | ~hit_any);
  wire logic rd_refused = do_rd & (~(hit_ro | hit_rw));

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  wire logic [31:0] rd_mux =
      hit_thr   ? {16'h0000, torque_threshold_level_reg} :
      hit_p3    ? {16'h0000, phase3_readiness_check_cmd_reg} :
      hit_p4    ? {16'h0000, phase4_readiness_check_cmd_reg} :
      hit_fault ? {16'h0000, vendor_fault_flags_reg} :
      hit_p1r   ? probe1_rise_capture :
      hit_p1f   ? probe1_fall_capture :
      hit_p2r   ? probe2_rise_capture :
      hit_p2f   ? probe2_fall_capture :
      hit_mcw   ? {16'h0000, master_control_word} :
      hit_dsw   ? {16'h0000, drive_status_word} :
      hit_acc   ? accel_limit_symmetric_reg :
      32'h00000000;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      svc_rsp <= '0;
    end else begin
      svc_rsp.valid <= svc_req.valid;
      svc_rsp.err   <= wr_refused | rd_refused;
      svc_rsp.rdata <= do_rd ? rd_mux : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Writable parameters
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      torque_threshold_level_reg     <= sdpsp_pkg::TORQUE_THR_RST;
      accel_limit_symmetric_reg      <= sdpsp_pkg::ACCEL_LIMIT_RST;
      phase3_readiness_check_cmd_reg <= sdpsp_pkg::PROC_RST;
      phase4_readiness_check_cmd_reg <= sdpsp_pkg::PROC_RST;
    end else begin
      if (wr_thr) begin
        torque_threshold_level_reg <= svc_req.wdata[15:0];
      end
      if (wr_acc) begin
        accel_limit_symmetric_reg <= svc_req.wdata;
      end
      if (wr_p3) begin
        phase3_readiness_check_cmd_reg <= svc_req.wdata[15:0];
      end
      if (wr_p4) begin
        phase4_readiness_check_cmd_reg <= svc_req.wdata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Readiness checks
  // ----------------------------------------------------------------
  // The check is evaluated once per execute write so a later change of the loaded flag
  // does not rewrite an acknowledgment the master may already have read.
  wire logic p3_exec = wr_p3 & (svc_req.wdata[15:0] == sdpsp_pkg::PROC_EXECUTE);
  wire logic p4_exec = wr_p4 & (svc_req.wdata[15:0] == sdpsp_pkg::PROC_EXECUTE);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      p3_check_status <= '0;
      p4_check_status <= '0;
    end else begin
      if (p3_exec) begin
        p3_check_status.active <= 1'b1;
        p3_check_status.done   <= p3_params_loaded;
        p3_check_status.error  <= ~p3_params_loaded;
      end else if (wr_p3) begin
        p3_check_status <= '0;
      end
      if (p4_exec) begin
        p4_check_status.active <= 1'b1;
        p4_check_status.done   <= p4_params_loaded;
        p4_check_status.error  <= ~p4_params_loaded;
      end else if (wr_p4) begin
        p4_check_status <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Class 3 status word
  // ----------------------------------------------------------------
  wire logic torque_reached = (torque_feedback > torque_threshold_level_reg);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      class3_status_word <= 16'h0000;
    end else begin
      class3_status_word <= 16'h0000;
      class3_status_word[sdpsp_pkg::C3_STANDSTILL_BIT] <= vel_standstill;
      class3_status_word[sdpsp_pkg::C3_BELOW_NX_BIT]   <= vel_below_nx;
      class3_status_word[sdpsp_pkg::C3_TORQUE_BIT]     <= torque_reached;
    end
  end

  // ----------------------------------------------------------------
  // Vendor fault latch
  // ----------------------------------------------------------------
  // A bit clears only with a reset command while its own condition is gone; a condition
  // present in the reset cycle keeps the bit set.
  always_comb begin
    vendor_fault_flags_next = vendor_fault_flags_reg;
    for (int i = 0; i < sdpsp_pkg::FAULT_USED_BITS; i++) begin
      if (fault_condition[i]) begin
        vendor_fault_flags_next[i] = 1'b1;
      end else if (c1_reset) begin
        vendor_fault_flags_next[i] = 1'b0;
      end
    end
    vendor_fault_flags_next[15:sdpsp_pkg::FAULT_USED_BITS] = '0;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      vendor_fault_flags_reg <= 16'h0000;
      class1_vendor_error    <= 1'b0;
    end else begin
      vendor_fault_flags_reg <= vendor_fault_flags_next;
      class1_vendor_error    <= |vendor_fault_flags_next;
    end
  end

  // ----------------------------------------------------------------
  // Probe capture
  // ----------------------------------------------------------------
  wire logic [31:0] probe_position = probe_source_sel ? external_position : motor_position;

  sdpsp_edge_capture #(
    .WIDTH        (32)
  ) u_probe1 (
    .core_clk     (core_clk),
    .arst_n       (arst_n),
    .probe        (probe1_in),
    .position     (probe_position),
    .rise_capture (probe1_rise_capture),
    .fall_capture (probe1_fall_capture)
  );

  sdpsp_edge_capture #(
    .WIDTH        (32)
  ) u_probe2 (
    .core_clk     (core_clk),
    .arst_n       (arst_n),
    .probe        (probe2_in),
    .position     (probe_position),
    .rise_capture (probe2_rise_capture),
    .fall_capture (probe2_fall_capture)
  );

  // ----------------------------------------------------------------
  // Acceleration clamp
  // ----------------------------------------------------------------
  // The limit never exceeds 2^31-1, so its negation is always representable.
  wire logic signed [31:0] acc_cmd_s = $signed(accel_command);
  wire logic signed [31:0] acc_lim_s = $signed(accel_limit_symmetric_reg);
  wire logic signed [31:0] acc_neg_s = -acc_lim_s;
  wire logic [31:0] acc_sel = (acc_cmd_s > acc_lim_s) ? accel_limit_symmetric_reg :
                              (acc_cmd_s < acc_neg_s) ? 32'(acc_neg_s) : accel_command;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      accel_clamped <= 32'h00000000;
    end else begin
      accel_clamped <= acc_sel;
    end
  end

endmodule : sdpsp_param_block

// >>> test/sdpsp_param_props.sv
// Purpose: Port-level checks for the servo drive parameter block.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes: Stored limits are hidden, so flag and clamp checks use bounds true for any setting.
`timescale 1ns/100ps
module sdpsp_param_props (
  input wire logic                   core_clk,
  input wire logic                   arst_n,
  input wire sdpsp_pkg::sdpsp_req_t  svc_req,
  input wire sdpsp_pkg::sdpsp_rsp_t  svc_rsp,
  input wire logic [2:0]             comm_phase,
  input wire logic                   p3_params_loaded,
  input wire logic                   p4_params_loaded,
  input wire sdpsp_pkg::sdpsp_proc_t p3_check_status,
  input wire sdpsp_pkg::sdpsp_proc_t p4_check_status,
  input wire logic [15:0]            torque_feedback,
  input wire logic                   vel_standstill,
  input wire logic                   vel_below_nx,
  input wire logic [15:0]            class3_status_word,
  input wire logic [6:0]             fault_condition,
  input wire logic                   class1_vendor_error,
  input wire logic [15:0]            master_control_word,
  input wire logic [15:0]            drive_status_word,
  input wire logic [31:0]            accel_clamped
);
  wire logic rd_take = svc_req.valid && !svc_req.write;
  wire logic wr_take = svc_req.valid && svc_req.write;
  wire logic diag_rst = wr_take && svc_req.param == sdpsp_pkg::PN_C1_RESET;
  wire logic run_chk = wr_take && svc_req.wdata == {16'h0000, sdpsp_pkg::PROC_EXECUTE};
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  ro_write_err_a: assert property (wr_take && svc_req.param inside {[16'h0081:16'h0087]} |=> svc_rsp.err)
    else $error("Write to a read-only parameter was accepted");
  ctrl_mirror_a: assert property (rd_take && svc_req.param == sdpsp_pkg::PN_MASTER_CTRL |=>
    !svc_rsp.err && svc_rsp.rdata == {16'h0000, $past(master_control_word)}) else $error("Bad control word read");
  stat_mirror_a: assert property (rd_take && svc_req.param == sdpsp_pkg::PN_DRIVE_STAT |=>
    !svc_rsp.err && svc_rsp.rdata == {16'h0000, $past(drive_status_word)}) else $error("Bad status word read");
  torque_full_a: assert property (torque_feedback == 16'hFFFF |=> class3_status_word[2])
    else $error("Torque flag missing at full feedback");
  vel_flags_a: assert property (1'b1 |=> class3_status_word[15:3] == 13'h0000 &&
    class3_status_word[1:0] == {$past(vel_below_nx), $past(vel_standstill)}) else $error("Bad velocity flags");
  fault_sets_a: assert property (fault_condition != 7'h00 |=> class1_vendor_error)
    else $error("Vendor error bit not set");
  fault_holds_a: assert property (class1_vendor_error && !diag_rst |=> class1_vendor_error)
    else $error("Vendor error bit cleared without reset");
  fault_clears_a: assert property (diag_rst && fault_condition == 7'h00 |=> !class1_vendor_error)
    else $error("Vendor error bit not cleared");
  p3_check_a: assert property (run_chk && svc_req.param == sdpsp_pkg::PN_P3_CHECK && comm_phase == 3'h2 |=>
    p3_check_status == {1'b1, $past(p3_params_loaded), !$past(p3_params_loaded)}) else $error("Bad phase 3 check");
  p4_check_a: assert property (run_chk && svc_req.param == sdpsp_pkg::PN_P4_CHECK && comm_phase == 3'h3 |=>
    p4_check_status == {1'b1, $past(p4_params_loaded), !$past(p4_params_loaded)}) else $error("Bad phase 4 check");
  accel_bound_a: assert property ($signed(accel_clamped) <= $signed(sdpsp_pkg::ACCEL_LIMIT_MAX) &&
    $signed(accel_clamped) >= -$signed(sdpsp_pkg::ACCEL_LIMIT_MAX)) else $error("Clamp beyond top limit");
endmodule : sdpsp_param_props
bind sdpsp_param_block sdpsp_param_props u_props (.core_clk, .arst_n, .svc_req, .svc_rsp, .comm_phase,
  .p3_params_loaded, .p4_params_loaded, .p3_check_status, .p4_check_status, .torque_feedback, .vel_standstill,
  .vel_below_nx, .class3_status_word, .fault_condition, .class1_vendor_error, .master_control_word,
  .drive_status_word, .accel_clamped);

// >>> test/sdpsp_master_model.sv
// Purpose: Ring master model issuing service channel requests and phase changes.
// Assumes: Requests are queued on a rising edge and driven on the next falling edge.
// Notes: An idle channel shows inverted data every cycle so stale fields are never trusted.
`timescale 1ns/100ps
module sdpsp_master_model (
  input  wire logic             core_clk,
  output sdpsp_pkg::sdpsp_req_t svc_req,
  output logic [2:0]            comm_phase
);
  sdpsp_pkg::sdpsp_req_t q[$];
  initial begin
    svc_req = '0;
    comm_phase = 3'h0;
  end
  always @(negedge core_clk) begin
    if (q.size() != 0) svc_req <= q.pop_front();
    else svc_req <= {1'b0, ~svc_req[48:0]};
  end
  task automatic send(input logic w, input logic [15:0] pn, input logic [31:0] wd);
    @(posedge core_clk);
    q.push_back({1'b1, w, pn, wd});
  endtask : send
  task automatic drain();
    while (q.size() != 0) @(posedge core_clk);
    @(posedge core_clk);
  endtask : drain
  task automatic set_phase(input logic [2:0] ph);
    @(negedge core_clk) comm_phase = ph;
  endtask : set_phase
  // A finished check is cancelled before the next phase is requested.
  task automatic finish_check(input logic [15:0] pn, input logic [2:0] ph);
    send(1'b1, pn, 32'h0);
    drain();
    set_phase(ph);
  endtask : finish_check
endmodule : sdpsp_master_model

// >>> test/tb_servo_drive_param_status_probe.sv
// Purpose: Self-checking bench for the servo drive parameter block.
// Assumes: Inputs change on the falling edge; answers are compared on the falling edge.
// Notes: Random data comes from an xorshift generator seeded with 57.
`timescale 1ns/100ps
module tb_servo_drive_param_status_probe;
  logic core_clk, arst_n, p3_params_loaded, p4_params_loaded, vel_standstill, vel_below_nx;
  logic probe1_in, probe2_in, probe_source_sel, class1_vendor_error;
  logic [2:0] comm_phase;
  logic [6:0] fault_condition;
  logic [15:0] torque_feedback, class3_status_word, master_control_word, drive_status_word, thr;
  logic [31:0] motor_position, external_position, accel_command, accel_clamped, lim, mag, ex;
  logic [31:0] seed = 32'h00000039;
  logic [31:0] v[4];
  logic [33:0] notes[$];
  sdpsp_pkg::sdpsp_req_t svc_req;
  sdpsp_pkg::sdpsp_rsp_t svc_rsp;
  sdpsp_pkg::sdpsp_proc_t p3_check_status, p4_check_status;
  int bad_count = 0;
  int cmp_count = 0;
  sdpsp_master_model u_master (.core_clk, .svc_req, .comm_phase);
  sdpsp_param_block u_dut (.core_clk, .arst_n, .svc_req, .svc_rsp, .comm_phase, .p3_params_loaded,
    .p4_params_loaded, .p3_check_status, .p4_check_status, .torque_feedback, .vel_standstill, .vel_below_nx,
    .class3_status_word, .fault_condition, .class1_vendor_error, .probe1_in, .probe2_in, .probe_source_sel,
    .motor_position, .external_position, .master_control_word, .drive_status_word, .accel_command, .accel_clamped);
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic ns(input logic w, input logic [15:0] pn, input logic [31:0] wd, input logic er, input logic [31:0] rd);
    notes.push_back({1'b1, er, rd});
    u_master.send(w, pn, wd);
  endtask : ns
  task automatic rq(input logic w, input logic [15:0] pn, input logic [31:0] wd, input logic er, input logic [31:0] rd);
    ns(w, pn, wd, er, rd);
    u_master.drain();
  endtask : rq
  task automatic summarize();
    if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    #400000;
    bad_count++;
    summarize();
  end
  // An answer with no note behind it compares against zero and fails.
  always @(negedge core_clk) begin
    if (svc_rsp.valid === 1'b1) chk(svc_rsp, notes.size() != 0 ? notes.pop_front() : 34'h0);
  end
  initial begin
    {arst_n, p3_params_loaded, p4_params_loaded, vel_standstill, vel_below_nx, probe1_in, probe2_in} = '0;
    {probe_source_sel, fault_condition, torque_feedback, master_control_word, drive_status_word} = '0;
    {motor_position, external_position, accel_command} = '0;
    repeat (20) @(negedge core_clk);
    arst_n = 1'b1;
    for (int p = 16'h007E; p <= 16'h008A; p++) begin
      rq(1'b0, 16'(p), 32'h0, p inside {16'h0088, 16'h0089},
        p == 16'h008A ? sdpsp_pkg::ACCEL_LIMIT_RST : 32'h0);
    end
    rq(1'b1, sdpsp_pkg::PN_TORQUE_THR, 32'h5, 1'b1, 32'h0);
    u_master.set_phase(3'h2);
    thr = 16'(xs() % 32'h00002711);
    rq(1'b1, sdpsp_pkg::PN_TORQUE_THR, {16'h0, thr}, 1'b0, 32'h0);
    rq(1'b1, sdpsp_pkg::PN_TORQUE_THR, 32'h00002711, 1'b1, 32'h0);
    rq(1'b0, sdpsp_pkg::PN_TORQUE_THR, 32'h0, 1'b0, {16'h0, thr});
    for (int i = 0; i < 4; i++) begin
      @(negedge core_clk) torque_feedback = i == 3 ? 16'hFFFF : (i == 2 ? 16'h0 : thr + 16'(i));
      {vel_below_nx, vel_standstill} = 2'(i);
      @(negedge core_clk) chk(class3_status_word, {31'h0, i[0], i[1], i[0]});
    end
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 2; i++) begin
        @(negedge core_clk) {p3_params_loaded, p4_params_loaded} = {2{i[0]}};
        rq(1'b1, 16'(sdpsp_pkg::PN_P3_CHECK + k), {16'h0, sdpsp_pkg::PROC_EXECUTE}, 1'b0, 32'h0);
        @(negedge core_clk) chk(k ? p4_check_status : p3_check_status, {1'b1, i[0], ~i[0]});
      end
      rq(1'b0, 16'(sdpsp_pkg::PN_P3_CHECK + k), 32'h0, 1'b0, {16'h0, sdpsp_pkg::PROC_EXECUTE});
      notes.push_back({2'b10, 32'h0});
      u_master.finish_check(16'(sdpsp_pkg::PN_P3_CHECK + k), 3'(3 + k));
      @(negedge core_clk) chk(k ? p4_check_status : p3_check_status, 34'h0);
      rq(1'b1, 16'(sdpsp_pkg::PN_P3_CHECK + k), {16'h0, sdpsp_pkg::PROC_EXECUTE}, 1'b1, 32'h0);
    end
    for (int i = 0; i < 8; i++) begin
      @(negedge core_clk) fault_condition = i < 7 ? 7'h01 << i : 7'h7F;
      @(negedge core_clk) fault_condition = i < 7 ? 7'h00 : 7'h7F;
      rq(1'b0, sdpsp_pkg::PN_VENDOR_FAULT, 32'h0, 1'b0, i < 7 ? 32'h1 << i : 32'h7F);
      rq(1'b1, sdpsp_pkg::PN_C1_RESET, xs(), 1'b0, 32'h0);
      @(negedge core_clk) chk(class1_vendor_error, i == 7);
    end
    @(negedge core_clk) fault_condition = 7'h00;
    rq(1'b1, sdpsp_pkg::PN_C1_RESET, 32'h0, 1'b0, 32'h0);
    rq(1'b0, sdpsp_pkg::PN_VENDOR_FAULT, 32'h0, 1'b0, 32'h0);
    for (int s = 0; s < 2; s++) begin
      @(negedge core_clk) probe_source_sel = s[0];
      for (int e = 0; e < 5; e++) begin
        @(negedge core_clk) v[e % 4] = e < 4 ? xs() : v[e % 4];
        motor_position = s ? ~xs() : v[e % 4];
        external_position = s ? v[e % 4] : ~xs();
        if (e < 2) probe1_in = ~e[0];
        else if (e < 4) probe2_in = ~e[0];
      end
      for (int e = 0; e < 4; e++) rq(1'b0, 16'(sdpsp_pkg::PN_P1_RISE + e), 32'h0, 1'b0, v[e]);
    end
    @(negedge core_clk) {master_control_word, drive_status_word} = xs();
    ns(1'b0, sdpsp_pkg::PN_MASTER_CTRL, 32'h0, 1'b0, {16'h0, master_control_word});
    ns(1'b0, sdpsp_pkg::PN_DRIVE_STAT, 32'h0, 1'b0, {16'h0, drive_status_word});
    u_master.drain();
    for (int p = 16'h0081; p <= 16'h0087; p++) rq(1'b1, 16'(p), 32'h0, 1'b1, 32'h0);
    lim = xs() % sdpsp_pkg::ACCEL_LIMIT_MAX + 32'h1;
    rq(1'b1, sdpsp_pkg::PN_ACCEL_LIMIT, lim, 1'b0, 32'h0);
    rq(1'b1, sdpsp_pkg::PN_ACCEL_LIMIT, sdpsp_pkg::ACCEL_LIMIT_MAX + 32'h1, 1'b1, 32'h0);
    rq(1'b0, sdpsp_pkg::PN_ACCEL_LIMIT, 32'h0, 1'b0, lim);
    for (int i = 0; i < 4; i++) begin
      mag = i[1] ? lim - 32'h1 : lim + 32'h1;
      ex = i[1] ? mag : lim;
      @(negedge core_clk) accel_command = i[0] ? -mag : mag;
      @(negedge core_clk) chk(accel_clamped, 32'(i[0] ? -ex : ex));
    end
    repeat (3) @(negedge core_clk);
    chk(34'(notes.size()), 34'h0);
    summarize();
  end
endmodule : tb_servo_drive_param_status_probe
